/* File: rtl/cc_pkg.sv */
// shared constants and carriers for the card aux/presence block
package cc_pkg;

  // presence filter counter width and default stable time
  localparam int unsigned FILT_W       = 16;
  localparam int unsigned FILT_TIME_NS = 1000;
  localparam int unsigned CLK_NS       = 10;
  localparam int unsigned FILT_CYCLES  =
    (FILT_TIME_NS + CLK_NS - 1) / CLK_NS;

  // reset values
  localparam logic       RST_PIN   = 1'h1;
  localparam logic [1:0] RST_FORCE = 2'h3;
  localparam logic       RST_SLOW  = 1'h0;
  localparam logic       RST_POL   = 1'h0;
  localparam logic       RST_SPEC  = 1'h0;

  // aux line index inside two-bit vectors
  localparam int unsigned AUX_A = 0;
  localparam int unsigned AUX_B = 1;

  // fields taken from the host command word
  typedef struct packed {
    logic slow_slope;
    logic pol_high;
    logic special_mode;
  } cc_cmd_s;

  // all state of the top module
  typedef struct packed {
    logic              cs_m;
    logic              cs_s;
    logic [1:0]        aux_m;
    logic [1:0]        aux_s;
    logic              pres_m;
    logic              pres_s;
    cc_cmd_s           cfg;
    logic [1:0]        force_lvl;
    logic              filt;
    logic [FILT_W-1:0] cnt;
    logic              clk_out;
    logic              slow_out;
    logic [1:0]        aux_oe;
    logic [1:0]        aux_rd;
    logic [1:0]        sel_id;
    logic              fb_bit;
    logic              card_in;
  } cc_state_s;

endpackage

/* File: rtl/cc_aux_pres.sv */
// card aux lines, card clock gating and card presence detection
// Function
// - aux line b serves sync cards or reports select id on bit 1
// - sampled aux line reads grounded as zero, tied high or open as one
// - async mode reads sensed level; sync mode reads last forced level
// - card clock follows clock selector, held low during supply start or 0 V
// - fast or slow card clock edge rate chosen by command field
// - presence input weakly pulled high, active-low switch to ground
// - presence input filtered against short spikes before use
// - presence switch polarity programmed by command field
// - normal mode: feedback bit high whenever a card is inserted
// - special mode: feedback bit mirrors switch state, ignoring polarity
// - aux line a serves sync cards or reports select id on bit 0
// - select high disables programming and card transactions
`timescale 1ns/1ps
`default_nettype none

module cc_aux_pres #(
  parameter int unsigned FILT_CYCLES = cc_pkg::FILT_CYCLES
) (
  input  wire logic           CLK_I,
  input  wire logic           RST_I,
  input  wire logic           SEL_N_I,
  input  wire logic           CMD_WR_I,
  input  wire cc_pkg::cc_cmd_s CMD_I,
  input  wire logic           SYNC_MODE_I,
  input  wire logic           AUX_WR_I,
  input  wire logic [1:0]     AUX_WD_I,
  input  wire logic [1:0]     AUX_I,
  output var  logic [1:0]     AUX_O,
  output var  logic [1:0]     AUX_OE_O,
  output var  logic [1:0]     AUX_RD_O,
  output var  logic [1:0]     SEL_ID_O,
  input  wire logic           CLK_SEL_I,
  input  wire logic           SUPPLY_START_I,
  input  wire logic           SUPPLY_ZERO_I,
  output var  logic           CARD_CLOCK_OUT_O,
  output var  logic           CLK_SLOW_O,
  input  wire logic           CARD_PRESENCE_IN_I,
  output var  logic           PRES_PULLUP_O,
  output var  logic           PRESENCE_FEEDBACK_BIT_O,
  output var  logic           CARD_IN_O
);

  // elaboration check: the counter must hold the stable time
  if (FILT_CYCLES < 1 || FILT_CYCLES >= (1 << cc_pkg::FILT_W)) begin : g_chk
    $error("FILT_CYCLES out of range");
  end

  localparam int unsigned FW = cc_pkg::FILT_W;
  localparam logic [FW-1:0] FILT_LAST = FW'(FILT_CYCLES - 1);

  cc_pkg::cc_state_s s_q;
  cc_pkg::cc_state_s s_d;

  logic sel_ok;
  logic inserted;

  always_comb begin
    s_d = s_q;

    // two-flop synchronisers for every pin input
    s_d.cs_m   = SEL_N_I;
    s_d.cs_s   = s_q.cs_m;
    s_d.aux_m  = AUX_I;
    s_d.aux_s  = s_q.aux_m;
    s_d.pres_m = CARD_PRESENCE_IN_I;
    s_d.pres_s = s_q.pres_m;

    // nothing is programmed while the unit is deselected
    sel_ok = ~s_q.cs_s;

    if (CMD_WR_I && sel_ok) begin
      s_d.cfg = CMD_I;
    end

    // forced levels only change on a card write while selected
    if (AUX_WR_I && sel_ok && SYNC_MODE_I) begin
      s_d.force_lvl = AUX_WD_I;
    end

    // open drain: pull low only when forcing a zero in sync mode
    s_d.aux_oe = SYNC_MODE_I ? ~s_q.force_lvl : 2'h0;

    // grounded line reads zero; tied high or open reads one
    // via the external pull-up resolved on the wire
    s_d.aux_rd = SYNC_MODE_I ? s_q.force_lvl : s_q.aux_s;

    // select identification straps, reported on id bits 0 and 1
    s_d.sel_id[cc_pkg::AUX_A] = s_q.aux_s[cc_pkg::AUX_A];
    s_d.sel_id[cc_pkg::AUX_B] = s_q.aux_s[cc_pkg::AUX_B];

    // card clock: one flop behind the selector, low while unpowered
    s_d.clk_out = CLK_SEL_I & ~SUPPLY_START_I & ~SUPPLY_ZERO_I;
    s_d.slow_out = s_q.cfg.slow_slope;

    // spike filter: level must hold for FILT_CYCLES clocks
    if (s_q.pres_s == s_q.filt) begin
      s_d.cnt = '0;
    end else if (s_q.cnt == FILT_LAST) begin
      s_d.filt = s_q.pres_s;
      s_d.cnt  = '0;
    end else begin
      s_d.cnt = s_q.cnt + FW'(1);
    end

    // polarity low means the switch closes to ground on insert
    inserted = s_q.filt ~^ s_q.cfg.pol_high;
    s_d.card_in = inserted;

    // special mode mirrors the filtered switch level directly
    if (s_q.cfg.special_mode) begin
      s_d.fb_bit = s_q.filt;
    end else begin
      s_d.fb_bit = inserted;
    end
  end

  always_ff @(posedge CLK_I or posedge RST_I) begin
    if (RST_I) begin
      s_q.cs_m             <= cc_pkg::RST_PIN;
      s_q.cs_s             <= cc_pkg::RST_PIN;
      s_q.aux_m            <= {2{cc_pkg::RST_PIN}};
      s_q.aux_s            <= {2{cc_pkg::RST_PIN}};
      s_q.pres_m           <= cc_pkg::RST_PIN;
      s_q.pres_s           <= cc_pkg::RST_PIN;
      s_q.cfg.slow_slope   <= cc_pkg::RST_SLOW;
      s_q.cfg.pol_high     <= cc_pkg::RST_POL;
      s_q.cfg.special_mode <= cc_pkg::RST_SPEC;
      s_q.force_lvl        <= cc_pkg::RST_FORCE;
      s_q.filt             <= cc_pkg::RST_PIN;
      s_q.cnt              <= '0;
      s_q.clk_out          <= 1'h0;
      s_q.slow_out         <= cc_pkg::RST_SLOW;
      s_q.aux_oe           <= 2'h0;
      s_q.aux_rd           <= 2'h3;
      s_q.sel_id           <= 2'h3;
      s_q.fb_bit           <= 1'h0;
      s_q.card_in          <= 1'h0;
    end else begin
      s_q <= s_d;
    end
  end

  // open-drain data is always zero; enable decides the pull
  assign AUX_O                   = 2'h0;
  assign AUX_OE_O                = s_q.aux_oe;
  assign AUX_RD_O                = s_q.aux_rd;
  assign SEL_ID_O                = s_q.sel_id;
  assign CARD_CLOCK_OUT_O        = s_q.clk_out;
  assign CLK_SLOW_O              = s_q.slow_out;
  // weak pull-up request stays on; the pad owns the current source
  assign PRES_PULLUP_O           = 1'h1;
  assign PRESENCE_FEEDBACK_BIT_O = s_q.fb_bit;
  assign CARD_IN_O               = s_q.card_in;

endmodule

`default_nettype wire

/* File: dv/cc_aux_pres_chk.sv */
// assertions on the card aux and presence block ports
`timescale 1ns/1ps
`default_nettype none
module cc_aux_pres_chk (
  input wire logic CLK_I, RST_I, SEL_N_I, CMD_WR_I, SYNC_MODE_I, AUX_WR_I,
  input wire logic CLK_SEL_I, SUPPLY_START_I, SUPPLY_ZERO_I, CLK_SLOW_O,
  input wire logic CARD_CLOCK_OUT_O, PRES_PULLUP_O, CARD_IN_O,
  input wire cc_pkg::cc_cmd_s CMD_I,
  input wire logic [1:0] AUX_WD_I, AUX_I, AUX_O, AUX_OE_O, SEL_ID_O
);
  // edges since reset, so no history reaches back into reset
  logic [2:0] up_q;
  always_ff @(posedge CLK_I or posedge RST_I)
    if (RST_I) up_q <= 3'h0; else if (!up_q[2]) up_q <= up_q + 3'h1;
  default clocking @(posedge CLK_I); endclocking
  default disable iff (RST_I);
  a_clk_gate: assert property (up_q != 3'h0 |-> CARD_CLOCK_OUT_O ==
    $past(CLK_SEL_I & ~SUPPLY_START_I & ~SUPPLY_ZERO_I)) else $error("clk");
  a_pull_up: assert property (PRES_PULLUP_O) else $error("pull");
  a_aux_data: assert property (AUX_O == 2'h0) else $error("data");
  a_sel_id: assert property (up_q > 3'h2 |->
    SEL_ID_O == $past(AUX_I, 3)) else $error("sel id");
  a_no_drive: assert property (!$past(SYNC_MODE_I, 2) &&
    !$past(SYNC_MODE_I) |-> AUX_OE_O == 2'h0) else $error("drive");
  a_slope_take: assert property (!SEL_N_I [*3] ##0 CMD_WR_I |=>
    ##1 CLK_SLOW_O == $past(CMD_I.slow_slope, 2)) else $error("slope");
  a_desel_hold: assert property (SEL_N_I [*3] ##0 CMD_WR_I |=>
    ##1 $stable(CLK_SLOW_O)) else $error("deselect");
  a_aux_force: assert property (!SEL_N_I [*3] ##0
    (AUX_WR_I && SYNC_MODE_I) ##1 SYNC_MODE_I |=>
    AUX_OE_O == ~$past(AUX_WD_I, 2)) else $error("force");
  c_slow: cover property (CLK_SLOW_O);
  c_card_in: cover property (CARD_IN_O);
  c_drive: cover property (AUX_OE_O != 2'h0);
endmodule
bind cc_aux_pres cc_aux_pres_chk chk_i (.*);
`default_nettype wire

/* File: dv/cc_card_model.sv */
// card side: open-drain aux lines and presence switch
`timescale 1ns/1ps
`default_nettype none
module cc_card_model (
  input  wire logic [1:0] oe_i, low_i,
  input  wire logic       closed_i,
  output var  logic [1:0] line_o,
  output var  logic       pres_o
);
  assign line_o = ~(oe_i | low_i); // pull-up unless someone pulls
  assign pres_o = ~closed_i; // switch to ground, pulled high when open
endmodule
`default_nettype wire

/* File: dv/cc_aux_pres_test.sv */
// self-checking bench for the card aux and presence block
`timescale 1ns/1ps
`default_nettype none
module cc_aux_pres_test;
  logic clk = '0, rst = '1, sel_n = '1, cwr = '0, sync = '0, awr = '0;
  logic cs = '0, st = '0, zr = '0, cl = '0, eck = '0, ck, slow, fb, cin, pres;
  logic [1:0] awd = 2'h3, low = 2'h0, aux, oe, rd, sid, q[$];
  logic [31:0] rs = 32'h5B, r;
  cc_pkg::cc_cmd_s cmd = '0;
  int errors = 0, n_compared = 0, run = 0;
  always #5 clk = ~clk;
  cc_card_model far (.oe_i(oe), .low_i(low), .closed_i(cl), .line_o(aux),
    .pres_o(pres));
  cc_aux_pres #(.FILT_CYCLES(2)) dut (.CLK_I(clk), .RST_I(rst),
    .SEL_N_I(sel_n), .CMD_WR_I(cwr), .CMD_I(cmd), .SYNC_MODE_I(sync),
    .AUX_WR_I(awr), .AUX_WD_I(awd), .AUX_I(aux), .AUX_O(), .AUX_OE_O(oe),
    .AUX_RD_O(rd), .SEL_ID_O(sid), .CLK_SEL_I(cs), .SUPPLY_START_I(st),
    .SUPPLY_ZERO_I(zr), .CARD_CLOCK_OUT_O(ck), .CLK_SLOW_O(slow),
    .CARD_PRESENCE_IN_I(pres), .PRES_PULLUP_O(),
    .PRESENCE_FEEDBACK_BIT_O(fb), .CARD_IN_O(cin));
  function automatic logic [31:0] xs();
    rs ^= rs << 13;
    rs ^= rs >> 17;
    rs ^= rs << 5;
    return rs;
  endfunction
  task automatic chk(input logic [1:0] g, e);
    n_compared++;
    if (g !== e) begin
      errors++;
      $display("CHECK FAILED %0t %h %h", $time, g, e);
    end
  endtask
  task automatic tally_and_finish();
    if (errors == 0 && n_compared > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
  endtask
  task automatic cmd_wr(input logic [2:0] c);
    tick(1);
    {cwr, cmd} <= {1'b1, c};
    tick(1);
    cwr <= 1'b0;
  endtask
  // model: gate one edge late, pins seen three edges late
  always @(posedge clk) begin
    if (rst) q = {};
    else begin
      chk({1'b0, ck}, {1'b0, eck});
      run = sync ? 0 : run + 1;
      q.push_back(aux);
      if (q.size() == 4) begin
        chk(sid, q[0]);
        if (run > 3) chk(rd, q[0]);
        q.delete(0);
      end
    end
    eck = cs & ~st & ~zr;
  end
  initial begin
    tick(10);
    rst <= 1'b0;
    for (int i = 0; i < 300; i++) begin
      tick(1);
      r = xs();
      {cs, st, zr, low} <= {r[0], &r[2:1], &r[4:3], r[6:5]};
    end
    low <= 2'h0;
    cmd_wr(3'h4);
    tick(4);
    chk({1'b0, slow}, 2'h0);
    sel_n <= 1'b0;
    tick(3);
    for (int c = 0; c < 8; c++) begin
      cmd_wr(c[2:0]);
      for (int p = 0; p < 2; p++) begin
        cl <= p[0];
        tick(10);
        chk({1'b0, slow}, {1'b0, c[2]});
        chk({fb, cin}, {c[0] ? ~p[0] : p[0] ^ c[1], p[0] ^ c[1]});
      end
    end
    // one-cycle spike must be swallowed by the filter
    cl <= 1'b0;
    tick(1);
    cl <= 1'b1;
    repeat (10) begin
      tick(1);
      chk({fb, cin}, 2'h0);
    end
    for (int k = 0; k < 5; k++) begin
      {sync, awr, awd} <= {k < 4, 1'b1, k[1:0]};
      tick(1);
      awr <= 1'b0;
      tick(4);
      chk(oe, k < 4 ? ~k[1:0] : 2'h0);
      if (k < 4) chk(rd, k[1:0]);
    end
    tally_and_finish();
  end
endmodule
`default_nettype wire
